// ===== design/tsr_pkg.sv
// shared constants, types and state codes for the temperature sensor readout
package tsr_pkg;
   // command byte values (register pointer targets)
   localparam logic [7:0] CMD_LOCAL_MAIN = 8'h00;
   localparam logic [7:0] CMD_REMOTE_MAIN = 8'h01;
   localparam logic [7:0] CMD_STATUS = 8'h02;
   localparam logic [7:0] CMD_CFG_RD = 8'h03;
   localparam logic [7:0] CMD_RATE_RD = 8'h04;
   localparam logic [7:0] CMD_CFG_WR = 8'h09;
   localparam logic [7:0] CMD_RATE_WR = 8'h0a;
   localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
   localparam logic [7:0] CMD_REMOTE_FRAC = 8'h10;
   localparam logic [7:0] CMD_LOCAL_FRAC = 8'h11;
   // bit positions
   localparam int CFG_STOP_BIT = 6;
   localparam int CFG_EXT_BIT = 5;
   localparam int CFG_PRC_BIT = 4;
   localparam int STAT_BUSY_BIT = 7;
   localparam int STAT_FAULT_BIT = 2;
   // reset values and masks
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h02;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] CFG_WR_MASK = 8'hf8;
   localparam logic [7:0] RATE_MAX = 8'h07;
   localparam logic [7:0] RATE_EXT_MAX = 8'h04;
   // default slave address, arbitrary value
   localparam logic [6:0] SMB_ADDR_DFLT = 7'h4c;
   // temperature codes
   localparam logic [7:0] TEMP_POS_SAT = 8'h7f;
   localparam logic [7:0] TEMP_NEG_CODE = 8'h80;
   localparam logic signed [9:0] TEMP_DEG_MAX = 10'sh07f;
   localparam logic signed [9:0] TEMP_EXT_MIN = -10'sh040;
   localparam logic signed [12:0] TEMP_HALF_EIGHTHS = 13'sh0004;
   // timing
   localparam int CONV_TIME_MS = 125;
   localparam int SYS_CLK_KHZ = 250000;
   localparam int CONV_CYC = CONV_TIME_MS * SYS_CLK_KHZ;

   // conversion results handed from the core to the serial side
   typedef struct packed {
      logic [7:0] local_main;
      logic [7:0] remote_main;
      logic [7:0] local_frac;
      logic [7:0] remote_frac;
      logic fault;
   } tsr_res_s;

   // software control handed from the serial side to the core
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] rate;
   } tsr_ctl_s;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_CMD = 3'b010,
      L_WDATA = 3'b011,
      L_RDATA = 3'b100,
      L_WAIT = 3'b101
   } tsr_link_e;

   typedef enum logic [0:0] {
      C_IDLE = 1'b0,
      C_CONV = 1'b1
   } tsr_conv_e;
endpackage

// ===== design/tsr_top.sv
// two-wire slave, standby control and conversion sequencer of the sensor readout
`timescale 1ns/1ps

// How it works
// - hardware sleep low or software stop bit disables converter, enters standby.
// - standby keeps all registers and keeps answering serial reads and writes.
// - one-shot is ignored while hardware sleep input is low.
// - software standby with sleep high: one-shot runs one conversion of both channels.
// - hardware sleep low overrides every software conversion request.
// - standby during conversion aborts it; old results stay, nothing updated.
// - conversion lasts 125 ms; rate timer alone runs between autoconversions.
// - one slave address answers for every register and command.
// - only Write Byte, Read Byte, Send Byte and Receive Byte are supported.
// - Write Byte: address, command, data, all acked; data stored only for commands 0x09 and 0x0a.
// - Read Byte: command, repeated start, read; device returns byte, host nacks.
// - Send Byte carries address and command only; mainly for one-shot.
// - Receive Byte returns register at the persistent pointer.
// - main temperatures are sign plus seven bits, one degree LSB, MSB first.
// - readings carry half-degree offset for rounding; top saturates at +127.
// - negatives read 0x80 normally; extended range two's complement; below -64 0x80.
// - fraction registers hold half, quarter, eighth degree in top three bits.
// - fraction bits valid only at 1 Hz or slower conversion rate.
// - main and fraction registers update together at conversion end, no lock.
// - configuration bit 4 enables series-resistance cancellation for remote channel, only at 1 Hz or slower rates.
// - one-shot arriving during a conversion is discarded.
// - status busy flag is set during conversion; old results remain readable.
// - configuration bit 6 set selects standby, clear selects autoconvert.
module tsr_top #(
   parameter int P_CONV_CYC = tsr_pkg::CONV_CYC,
   parameter logic [6:0] P_SLAVE_ADDR = tsr_pkg::SMB_ADDR_DFLT
) (
   // core clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // serial link
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   // standby pin
   input wire logic i_hw_sleep_n,
   // converter front end, signed eighths of a degree
   input wire logic [11:0] i_local_eighths,
   input wire logic [11:0] i_remote_eighths,
   input wire logic i_remote_fault,
   // converter control
   output logic o_adc_en,
   output logic o_prc_en
);
   import tsr_pkg::*;

   localparam int CNT_W = $clog2(P_CONV_CYC + 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(P_CONV_CYC - 1);

   // round to nearest degree and clip into the byte code
   function automatic logic [7:0] temp_main(input logic [11:0] t, input logic ext,
                                            input logic fault);
      logic signed [12:0] r;
      logic signed [9:0] deg;
      logic [7:0] code;
      r = $signed({t[11], t}) + TEMP_HALF_EIGHTHS;
      deg = r[12:3];
      if (fault) begin
         code = TEMP_NEG_CODE;
      end else if (deg >= TEMP_DEG_MAX) begin
         code = TEMP_POS_SAT;
      end else if (deg < 0) begin
         code = (!ext || deg < TEMP_EXT_MIN) ? TEMP_NEG_CODE : deg[7:0];
      end else begin
         code = deg[7:0];
      end
      return code;
   endfunction

   // autoconvert interval in 125 ms ticks; faster codes clamp at the top rate
   function automatic logic [7:0] rate_div(input logic [7:0] rate);
      logic [2:0] sh;
      sh = (rate > RATE_MAX) ? 3'h0 : 3'(RATE_MAX - rate);
      return 8'h01 << sh;
   endfunction

   // ---------------- core domain ----------------
   logic hw_s1_r, hw_s2_r;
   logic ctl_s1_r, ctl_s2_r, ctl_s3_r;
   logic os_s1_r, os_s2_r, os_s3_r;
   tsr_ctl_s ctl_sys_r;
   tsr_conv_e conv_st_r;
   logic [CNT_W-1:0] conv_cnt_r, tmr_cnt_r;
   logic [7:0] tick_cnt_r;
   logic auto_pend_r, stop_q_r, busy_r, res_tgl_r;
   tsr_res_s res_sys_r;
   logic adc_en_r, prc_en_r;
   logic hw_awake, stop, os_evt, ext_res, start, abort, done;

   // link-domain state read by the crossings
   tsr_ctl_s ctl_link_r;
   logic ctl_tgl_r, os_tgl_r;

   // the sleep pin is asynchronous: two flops before anything looks at it
   // sleep pin synchroniser
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hw_s1_r <= 1'b0;
         hw_s2_r <= 1'b0;
      end else begin
         hw_s1_r <= i_hw_sleep_n;
         hw_s2_r <= hw_s1_r;
      end
   end

   // control words and one-shot events arrive as toggles from the link side
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_s1_r <= 1'b0;
         ctl_s2_r <= 1'b0;
         ctl_s3_r <= 1'b0;
         os_s1_r <= 1'b0;
         os_s2_r <= 1'b0;
         os_s3_r <= 1'b0;
      end else begin
         ctl_s1_r <= ctl_tgl_r;
         ctl_s2_r <= ctl_s1_r;
         ctl_s3_r <= ctl_s2_r;
         os_s1_r <= os_tgl_r;
         os_s2_r <= os_s1_r;
         os_s3_r <= os_s2_r;
      end
   end

   // the link word was stable for two core cycles before its toggle shows here
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctl_sys_r <= '{cfg: CFG_RST, rate: RATE_RST};
      end else if (ctl_s2_r ^ ctl_s3_r) begin
         ctl_sys_r <= ctl_link_r;
      end
   end

   assign hw_awake = hw_s2_r;
   assign stop = ctl_sys_r.cfg[CFG_STOP_BIT];
   assign os_evt = os_s2_r ^ os_s3_r;
   assign ext_res = ctl_sys_r.rate <= RATE_EXT_MAX;
   // one-shot only with sleep pin high; autoconvert needs both awake
   assign start = (conv_st_r == C_IDLE) && hw_awake && (os_evt || (!stop && auto_pend_r));
   // abort on either standby request; a stop already set lets a one-shot finish
   assign abort = (conv_st_r == C_CONV) && (!hw_awake || (stop && !stop_q_r));
   assign done = (conv_st_r == C_CONV) && !abort && (conv_cnt_r == CONV_LAST);

   // conversion sequencer
   // one-shot ignored when busy
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_st_r <= C_IDLE;
         conv_cnt_r <= '0;
         stop_q_r <= 1'b0;
      end else begin
         stop_q_r <= stop;
         case (conv_st_r)
            C_IDLE: begin
               conv_cnt_r <= '0;
               if (start) begin
                  conv_st_r <= C_CONV;
               end
            end
            C_CONV: begin
               conv_cnt_r <= conv_cnt_r + 1'b1;
               if (abort || done) begin
                  conv_st_r <= C_IDLE;
               end
            end
            default: conv_st_r <= C_IDLE;
         endcase
      end
   end

   // rate timer runs from each conversion start, also during and after it
   // rate timer between conversions
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tmr_cnt_r <= '0;
         tick_cnt_r <= 8'h00;
         auto_pend_r <= 1'b1;
      end else if (stop || !hw_awake || start) begin
         tmr_cnt_r <= '0;
         tick_cnt_r <= 8'h00;
         auto_pend_r <= stop || !hw_awake;
      end else if (tmr_cnt_r == CONV_LAST) begin
         tmr_cnt_r <= '0;
         if (tick_cnt_r >= rate_div(ctl_sys_r.rate) - 8'h01) begin
            tick_cnt_r <= 8'h00;
            auto_pend_r <= 1'b1;
         end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
         end
      end else begin
         tmr_cnt_r <= tmr_cnt_r + 1'b1;
      end
   end

   // results change only on a completed conversion, all four at once
   // result update
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         res_sys_r <= '0;
         res_tgl_r <= 1'b0;
      end else if (done) begin
         res_sys_r.local_main <= temp_main(i_local_eighths, ctl_sys_r.cfg[CFG_EXT_BIT], 1'b0);
         res_sys_r.remote_main <= temp_main(i_remote_eighths, ctl_sys_r.cfg[CFG_EXT_BIT],
                                            i_remote_fault);
         res_sys_r.local_frac <= ext_res ? {i_local_eighths[2:0], 5'h00} : 8'h00;
         res_sys_r.remote_frac <= (ext_res && !i_remote_fault) ?
                                  {i_remote_eighths[2:0], 5'h00} : 8'h00;
         res_sys_r.fault <= i_remote_fault;
         res_tgl_r <= ~res_tgl_r;
      end
   end

   // converter controls and busy flag; cancellation only applies at slow rates
   // converter enables
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adc_en_r <= 1'b0;
         prc_en_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         adc_en_r <= start || ((conv_st_r == C_CONV) && !abort && !done);
         busy_r <= start || ((conv_st_r == C_CONV) && !abort && !done);
         prc_en_r <= ctl_sys_r.cfg[CFG_PRC_BIT] && ext_res;
      end
   end

   assign o_adc_en = adc_en_r;
   assign o_prc_en = prc_en_r;

   // ---------------- link domain ----------------
   logic scl_s1_r, scl_s2_r, scl_q_r, sda_s1_r, sda_s2_r, sda_q_r;
   logic rt_s1_r, rt_s2_r, rt_s3_r, busy_s1_r, busy_s2_r;
   tsr_res_s res_link_r;
   tsr_link_e lk_st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, tx_r, ptr_r;
   logic ack_ph_r, sda_oe_n_r, sda_out_r;
   logic start_det, stop_det, scl_rise, scl_fall, byte_end, cmd_strobe, data_strobe;

   // register read decode
   function automatic logic [7:0] rd_mux(input logic [7:0] p, input tsr_res_s r,
                                         input tsr_ctl_s c, input logic bsy);
      logic [7:0] v;
      v = 8'h00;
      case (p)
         CMD_LOCAL_MAIN: v = r.local_main;
         CMD_REMOTE_MAIN: v = r.remote_main;
         CMD_LOCAL_FRAC: v = r.local_frac;
         CMD_REMOTE_FRAC: v = r.remote_frac;
         CMD_STATUS: begin
            v[STAT_BUSY_BIT] = bsy;
            v[STAT_FAULT_BIT] = r.fault;
         end
         CMD_CFG_RD: v = c.cfg;
         CMD_RATE_RD: v = c.rate;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // bus pins and core state crossing into the link clock
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_q_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_q_r <= 1'b1;
         rt_s1_r <= 1'b0;
         rt_s2_r <= 1'b0;
         rt_s3_r <= 1'b0;
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
      end else begin
         scl_s1_r <= i_scl;
         scl_s2_r <= scl_s1_r;
         scl_q_r <= scl_s2_r;
         sda_s1_r <= i_sda;
         sda_s2_r <= sda_s1_r;
         sda_q_r <= sda_s2_r;
         rt_s1_r <= res_tgl_r;
         rt_s2_r <= rt_s1_r;
         rt_s3_r <= rt_s2_r;
         busy_s1_r <= busy_r;
         busy_s2_r <= busy_s1_r;
      end
   end

   // results are copied whole, so a read never mixes two conversions in one byte
   // old results readable
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         res_link_r <= '0;
      end else if (rt_s2_r ^ rt_s3_r) begin
         res_link_r <= res_sys_r;
      end
   end

   assign start_det = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
   assign stop_det = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;
   assign scl_rise = scl_s2_r && !scl_q_r;
   assign scl_fall = !scl_s2_r && scl_q_r;
   assign byte_end = scl_fall && !ack_ph_r && (cnt_r == 4'h8);
   assign cmd_strobe = byte_end && (lk_st_r == L_CMD);
   assign data_strobe = byte_end && (lk_st_r == L_WDATA);

   // byte protocol engine; sda changes only after a falling clock edge
   // four transaction types only
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lk_st_r <= L_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         ack_ph_r <= 1'b0;
         sda_oe_n_r <= 1'b1;
      end else if (start_det) begin
         lk_st_r <= L_ADDR;
         cnt_r <= 4'h0;
         ack_ph_r <= 1'b0;
         sda_oe_n_r <= 1'b1;
      end else if (stop_det) begin
         lk_st_r <= L_IDLE;
         cnt_r <= 4'h0;
         ack_ph_r <= 1'b0;
         sda_oe_n_r <= 1'b1;
      end else begin
         case (lk_st_r)
            L_ADDR, L_CMD, L_WDATA: begin
               if (scl_rise && !ack_ph_r) begin
                  sh_r <= {sh_r[6:0], sda_s2_r};
                  cnt_r <= cnt_r + 4'h1;
               end else if (byte_end) begin
                  if (lk_st_r == L_ADDR && sh_r[7:1] != P_SLAVE_ADDR) begin
                     lk_st_r <= L_WAIT;
                  end else begin
                     ack_ph_r <= 1'b1;
                     sda_oe_n_r <= 1'b0;
                     tx_r <= rd_mux(ptr_r, res_link_r, ctl_link_r, busy_s2_r);
                  end
               end else if (scl_fall && ack_ph_r) begin
                  ack_ph_r <= 1'b0;
                  cnt_r <= 4'h0;
                  sda_oe_n_r <= 1'b1;
                  case (lk_st_r)
                     L_ADDR: begin
                        if (sh_r[0]) begin
                           // first data bit is the MSB
                           lk_st_r <= L_RDATA;
                           sda_oe_n_r <= tx_r[7];
                           tx_r <= {tx_r[6:0], 1'b0};
                           cnt_r <= 4'h1;
                        end else begin
                           lk_st_r <= L_CMD;
                        end
                     end
                     L_CMD: lk_st_r <= L_WDATA;
                     // one data byte, extra bytes are not acked
                     default: lk_st_r <= L_WAIT;
                  endcase
               end
            end
            L_RDATA: begin
               if (scl_fall && !ack_ph_r) begin
                  if (cnt_r == 4'h8) begin
                     sda_oe_n_r <= 1'b1;
                     ack_ph_r <= 1'b1;
                  end else begin
                     sda_oe_n_r <= tx_r[7];
                     tx_r <= {tx_r[6:0], 1'b0};
                     cnt_r <= cnt_r + 4'h1;
                  end
               end else if (scl_rise && ack_ph_r) begin
                  // host nack ends the read with the line released
                  ack_ph_r <= 1'b0;
                  cnt_r <= 4'h0;
                  tx_r <= rd_mux(ptr_r, res_link_r, ctl_link_r, busy_s2_r);
                  if (sda_s2_r) begin
                     lk_st_r <= L_WAIT;
                  end
               end
            end
            default: begin
               sda_oe_n_r <= 1'b1;
            end
         endcase
      end
   end

   // pointer, control registers and one-shot toggle; all live through standby
   // register writes
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ptr_r <= PTR_RST;
         ctl_link_r <= '{cfg: CFG_RST, rate: RATE_RST};
         ctl_tgl_r <= 1'b0;
         os_tgl_r <= 1'b0;
      end else if (cmd_strobe) begin
         ptr_r <= sh_r;
         if (sh_r == CMD_ONE_SHOT) begin
            os_tgl_r <= ~os_tgl_r;
         end
      end else if (data_strobe && ptr_r == CMD_CFG_WR) begin
         ctl_link_r.cfg <= sh_r & CFG_WR_MASK;
         ctl_tgl_r <= ~ctl_tgl_r;
      end else if (data_strobe && ptr_r == CMD_RATE_WR) begin
         ctl_link_r.rate <= sh_r;
         ctl_tgl_r <= ~ctl_tgl_r;
      end
   end

   // the pad only ever pulls low; the enable carries the data
   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_out_r <= 1'b0;
      end else begin
         sda_out_r <= 1'b0;
      end
   end

   assign o_sda = sda_out_r;
   assign o_sda_oe_n = sda_oe_n_r;
endmodule

// ===== verif/tsr_top_sva.sv
// checker for the sensor readout ports: standby gating, conversion length, pad use
`timescale 1ns/1ps
module tsr_top_chk #(
   parameter int P_CONV_CYC = tsr_pkg::CONV_CYC,
   parameter logic [6:0] P_SLAVE_ADDR = tsr_pkg::SMB_ADDR_DFLT
) (
   // clocks and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   // serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe_n,
   // standby and converter
   input wire logic i_hw_sleep_n,
   input wire logic [11:0] i_local_eighths,
   input wire logic [11:0] i_remote_eighths,
   input wire logic i_remote_fault,
   input wire logic o_adc_en,
   input wire logic o_prc_en
);
   import tsr_pkg::*;
   int conv_cnt_r;
   // length of the running conversion; a counter because repetition cannot reach it
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_cnt_r <= 0;
      end else if (o_adc_en) begin
         conv_cnt_r <= conv_cnt_r + 1;
      end else begin
         conv_cnt_r <= 0;
      end
   end
   a_sleep_holds_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_hw_sleep_n) [*5] |-> !o_adc_en) else $error("converter ran in hardware standby");
   a_sleep_aborts: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_adc_en && !i_hw_sleep_n |-> ##[1:4] !o_adc_en) else $error("conversion not aborted");
   a_conv_bound: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      conv_cnt_r <= P_CONV_CYC) else $error("conversion ran too long");
   a_rst_core_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> !o_adc_en && !o_prc_en) else $error("core outputs active at reset");
   a_rst_link_idle: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> o_sda_oe_n) else $error("data line driven at reset");
   a_start_quiet: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      i_scl && $past(i_scl) && $fell(i_sda) |=> o_sda_oe_n [*4]) else $error("drive at start");
   a_drive_on_low: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      $changed(o_sda_oe_n) |-> !i_scl) else $error("data line changed with clock high");
   a_pad_low: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
      o_sda == 1'b0) else $error("pad value not low");
   // main scenarios reached
   c_conv: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_adc_en));
   c_abort: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_adc_en && !i_hw_sleep_n);
   c_ack: cover property (@(posedge i_link_clk) disable iff (!i_rst_n) $fell(o_sda_oe_n));
endmodule

bind tsr_top tsr_top_chk #(.P_CONV_CYC(P_CONV_CYC), .P_SLAVE_ADDR(P_SLAVE_ADDR)) chk (
   .i_sys_clk, .i_rst_n, .i_link_clk, .i_scl, .i_sda, .o_sda, .o_sda_oe_n, .i_hw_sleep_n,
   .i_local_eighths, .i_remote_eighths, .i_remote_fault, .o_adc_en, .o_prc_en);

// ===== verif/tsr_host.sv
// two-wire host model: drives the clock line and pulls the data line low
`timescale 1ns/1ps
module tsr_host (
   // timing clock
   input wire logic i_clk,
   // bus wires
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   import tsr_pkg::*;
   logic [6:0] addr_r = SMB_ADDR_DFLT;
   // idle bus: both lines released
   initial begin
      o_scl <= 1'b1;
      o_sda_low <= 1'b0;
   end
   task tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask
   // one bit: data moves mid-low, long setup keeps the slave's sampler safe
   task bit_slot(input logic b, output logic s);
      tick(4);
      o_sda_low <= ~b;
      tick(8);
      o_scl <= 1'b1;
      tick(8);
      s = i_sda;
      tick(4);
      o_scl <= 1'b0;
   endtask
   // start or repeated start: data falls while clock high
   task start_cond();
      tick(4);
      o_sda_low <= 1'b0;
      tick(8);
      o_scl <= 1'b1;
      tick(8);
      o_sda_low <= 1'b1;
      tick(8);
      o_scl <= 1'b0;
   endtask
   // stop: data rises while clock high
   task stop_cond();
      tick(4);
      o_sda_low <= 1'b1;
      tick(8);
      o_scl <= 1'b1;
      tick(8);
      o_sda_low <= 1'b0;
      tick(8);
   endtask
   task byte_slot(input logic [7:0] d, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         bit_slot(d[i], q[i]);
      end
      bit_slot(1'b1, nak);
   endtask
   // kinds: 0 write, 1 read, 2 send, 3 receive
   task xfer(input logic [1:0] kind, input logic [7:0] cmd, input logic [7:0] dat,
         output logic [7:0] q, output logic [1:0] nak);
      logic a;
      nak = 2'h0;
      start_cond();
      if (kind != 2'h3) begin
         byte_slot({addr_r, 1'b0}, q, a);
         nak = nak + {1'b0, a};
         byte_slot(cmd, q, a);
         nak = nak + {1'b0, a};
      end
      if (kind == 2'h0) begin
         byte_slot(dat, q, a);
         nak = nak + {1'b0, a};
      end
      if (kind == 2'h1) begin
         start_cond();
      end
      if (kind[0]) begin
         byte_slot({addr_r, 1'b1}, q, a);
         nak = nak + {1'b0, a};
         byte_slot(8'hff, q, a);
      end
      stop_cond();
   endtask
endmodule

// ===== verif/tsr_top_test.sv
// bench for the sensor readout: bus transfers, standby modes and data format
`timescale 1ns/1ps
module tsr_top_test;
   import tsr_pkg::*;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep_n = 1'b1;
   logic fault = 1'b0;
   logic [11:0] rem = 12'h000;
   logic [11:0] loc = 12'h0ca;
   logic sda;
   logic oe_n;
   logic adc;
   logic prc;
   logic [7:0] q;
   logic [1:0] n;
   wire scl;
   wire host_low;
   // pulled-up data wire, low when either party pulls
   wire sda_w = (oe_n ? 1'b1 : sda) & ~host_low;
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [11:0] tv [8] = '{12'h410, 12'h004, 12'h3f4, 12'h000, 12'hff8, 12'hff8, 12'hdf8, 12'h0ca};
   logic [7:0] te [8] = '{8'h7f, 8'h01, 8'h7f, 8'h00, 8'h80, 8'hff, 8'h80, 8'h19};
   // core and link clocks, unrelated in phase
   initial forever #2 clk = ~clk;
   initial begin
      #1.3;
      forever #3 lclk = ~lclk;
   end
   tsr_top #(.P_CONV_CYC(20)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk),
      .i_scl(scl), .i_sda(sda_w), .o_sda(sda), .o_sda_oe_n(oe_n), .i_hw_sleep_n(sleep_n),
      .i_local_eighths(loc), .i_remote_eighths(rem), .i_remote_fault(fault),
      .o_adc_en(adc), .o_prc_en(prc));
   tsr_host host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(host_low));
   task chk(input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task rdc(input logic [7:0] c, input logic [7:0] e);
      host.xfer(2'h1, c, 8'h00, q, n);
      chk(q, e);
   endtask
   task wrc(input logic [7:0] c, input logic [7:0] d, input logic [1:0] e);
      host.xfer(2'h0, c, d, q, n);
      chk({6'h00, n}, {6'h00, e});
   endtask
   // the conversion finishes inside the stop of the send byte, so a fixed wait covers it
   task shot();
      host.xfer(2'h2, CMD_ONE_SHOT, 8'h00, q, n);
      repeat (40) @(posedge clk);
   endtask
   task wait_adc(input logic v);
      int k;
      k = 0;
      while (adc !== v && k < 3000) begin
         @(posedge clk);
         k++;
      end
      chk({7'h00, adc}, {7'h00, v});
   endtask
   task conclude();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_adc(1'b1);
      wait_adc(1'b0);
      host.xfer(2'h3, 8'h00, 8'h00, q, n);
      chk(q, 8'h19);
      rdc(CMD_LOCAL_FRAC, 8'h40);
      wrc(CMD_CFG_WR, 8'h40, 2'h0);
      rdc(CMD_CFG_RD, 8'h40);
      rem <= 12'h410;
      repeat (800) @(posedge clk);
      rdc(CMD_REMOTE_MAIN, 8'h00);
      for (int i = 0; i < 8; i++) begin
         if (i == 5) wrc(CMD_CFG_WR, 8'h60, 2'h0);
         rem <= tv[i];
         shot();
         rdc(CMD_REMOTE_MAIN, te[i]);
      end
      rdc(CMD_REMOTE_FRAC, 8'h40);
      fault <= 1'b1;
      loc <= 12'hff8;
      shot();
      rdc(CMD_REMOTE_MAIN, 8'h80);
      rdc(CMD_LOCAL_MAIN, 8'hff);
      rdc(CMD_STATUS, 8'h04);
      fault <= 1'b0;
      loc <= 12'h0ca;
      sleep_n <= 1'b0;
      rem <= 12'h004;
      wrc(CMD_CFG_WR, 8'h00, 2'h0);
      shot();
      repeat (800) @(posedge clk);
      rdc(CMD_REMOTE_MAIN, 8'h80);
      sleep_n <= 1'b1;
      wait_adc(1'b1);
      wait_adc(1'b0);
      wait_adc(1'b1);
      rem <= 12'h410;
      sleep_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk({7'h00, adc}, 8'h00);
      rdc(CMD_REMOTE_MAIN, 8'h01);
      sleep_n <= 1'b1;
      wrc(CMD_CFG_WR, 8'h10, 2'h0);
      repeat (10) @(posedge clk);
      chk({7'h00, prc}, 8'h01);
      // fastest rate keeps the converter nearly always busy, so a status read catches it
      wrc(CMD_RATE_WR, 8'h07, 2'h0);
      q = 8'h00;
      for (int j = 0; j < 4 && !q[STAT_BUSY_BIT]; j++) begin
         host.xfer(2'h1, CMD_STATUS, 8'h00, q, n);
      end
      chk(q, 8'h80);
      wrc(CMD_RATE_WR, 8'h05, 2'h0);
      repeat (3) begin
         wait_adc(1'b1);
         wait_adc(1'b0);
      end
      chk({7'h00, prc}, 8'h00);
      rdc(CMD_LOCAL_FRAC, 8'h00);
      // poll busy until clear, then read at once
      q = 8'h80;
      for (int j = 0; j < 8 && q[STAT_BUSY_BIT]; j++) begin
         host.xfer(2'h1, CMD_STATUS, 8'h00, q, n);
      end
      chk(q, 8'h00);
      rdc(CMD_LOCAL_MAIN, 8'h19);
      host.addr_r <= 7'h4d;
      wrc(CMD_CFG_WR, 8'h40, 2'h3);
      host.addr_r <= SMB_ADDR_DFLT;
      rdc(CMD_CFG_RD, 8'h10);
      wrc(CMD_LOCAL_MAIN, 8'h55, 2'h0);
      rdc(CMD_LOCAL_MAIN, 8'h19);
      conclude();
   end
endmodule
